// ---- ioerp_consts.vh ----
// What this block does
// - Pin buffer plus registers, SDR or DDR
// - Output and enable paths combinational or registered; input bypass via two flops
// - Data registers clocked only by core clocks
// - Half-rate stage runs on core full-rate clock by phase
// - Full-rate stage runs on core full-rate clock
// - Input: SDR/DDR capture, half/full rate out
// - Output: half/full rate in, SDR/DDR drive
// - Output enable: half/full in, SDR only out
// - Clock enable, reset async or sync selectable
// - Bypass mode on input and output paths
// - Delay chains on input and output paths
// - Low-voltage bank pins: bypass paths only (input still through two flops)
// - Differential bank: four lanes of twelve pins
// - Edge speed 0 slow 1 fast, reset 1
// - Open drain per pin, reset off
// - Keeper and pull-up exclusive, both reset off
// - Swing code 0..3, reset 2
// - On-die termination forces fast edges
//
// Purpose: constants of the pin cell register path
// Assumes: APB slave, 32-bit data, byte addresses
// Notes:   definitions only
`ifndef IOERP_CONSTS_VH
`define IOERP_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define IOERP_ADDR_CTRL      8'h00
`define IOERP_ADDR_DRIVE     8'h04
`define IOERP_ADDR_DELAY     8'h08
`define IOERP_ADDR_STATUS    8'h0c

// ----------------------------------------
// Control fields
// ----------------------------------------
`define IOERP_CTRL_IN_DDR    0
`define IOERP_CTRL_OUT_DDR   1
`define IOERP_CTRL_HALF      2
`define IOERP_CTRL_IN_BYP    3
`define IOERP_CTRL_OUT_BYP   4
`define IOERP_CTRL_OE_BYP    5
`define IOERP_CTRL_SYNC_RST  6
`define IOERP_CTRL_GRP_OUT   7
`define IOERP_CTRL_W         8
`define IOERP_CTRL_RESET     8'h00

// ----------------------------------------
// Driver setting fields
// ----------------------------------------
`define IOERP_DRV_EDGE_FAST  0
`define IOERP_DRV_OPEN_DRAIN 1
`define IOERP_DRV_KEEPER     2
`define IOERP_DRV_PULL_UP    3
`define IOERP_DRV_BOOST      4
`define IOERP_DRV_SWING_LO   5
`define IOERP_DRV_SWING_HI   6
`define IOERP_DRV_SERIES     7
`define IOERP_DRV_ODT        8
`define IOERP_DRV_W          9
`define IOERP_DRV_RESET      9'h051

// ----------------------------------------
// Delay fields and organisation
// ----------------------------------------
`define IOERP_DLY_IN_LO      0
`define IOERP_DLY_IN_HI      2
`define IOERP_DLY_OUT_LO     8
`define IOERP_DLY_OUT_HI     10
`define IOERP_DLY_DEPTH      8
`define IOERP_LANES          4
`define IOERP_PINS_PER_LANE  12
`define IOERP_GROUP_PINS     8

`endif

// ---- ioerp_delay_chain.v ----
// Purpose: programmable cycle delay chain
// Assumes: tap below DEPTH
// Notes:   tap 0 passes straight through
`timescale 1ns/100ps
module ioerp_delay_chain #(
    parameter W     = 3,
    parameter DEPTH = 8,
    parameter SELW  = 3
) (
    input  wire            pclk,      // Full-rate core clock
    input  wire            rst_n,     // Async path reset, low
    input  wire            ce,        // Clock enable
    input  wire            clr,       // Sync clear
    input  wire [W-1:0]    din,       // Chain input
    input  wire [SELW-1:0] tap,       // Delay in cycles
    output wire [W-1:0]    dout       // Delayed data
);

    reg [W-1:0] stage_r [0:DEPTH-1];

    // ----------------------------------------
    // Shift stages
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < DEPTH; g = g + 1) begin : g_stage
            wire [W-1:0] prev;
            // First stage feeds from the input, no index below zero
            if (g == 0) begin : g_head
                assign prev = din;
            end else begin : g_tail
                assign prev = stage_r[g-1];
            end
            always @(posedge pclk or negedge rst_n) begin
                if (!rst_n) begin
                    stage_r[g] <= {W{1'b0}};
                end else if (ce) begin
                    if (clr) begin
                        stage_r[g] <= {W{1'b0}};
                    end else begin
                        stage_r[g] <= prev;
                    end
                end
            end
        end
    endgenerate

    assign dout = (tap == {SELW{1'b0}}) ? din : stage_r[tap - 1'b1];

endmodule // ioerp_delay_chain

// ---- ioerp_ddr_out.v ----
// Purpose: double data rate output register pair
// Assumes: d_rise and d_fall change only at rising edges
// Notes:   xor pair avoids muxing on the clock
`timescale 1ns/100ps
module ioerp_ddr_out (
    input  wire pclk,      // Full-rate core clock
    input  wire rst_n,     // Async path reset, low
    input  wire ce,        // Clock enable
    input  wire clr,       // Sync clear
    input  wire ddr_en,    // High for double data rate
    input  wire d_rise,    // Bit for high half
    input  wire d_fall,    // Bit for low half
    output wire q          // Pin data
);

    reg pos_r;
    reg neg_r;

    wire rise_bit = clr ? 1'b0 : d_rise;
    wire fall_bit = clr ? 1'b0 : (ddr_en ? d_fall : d_rise);

    // ----------------------------------------
    // Rising and falling halves
    // ----------------------------------------
    always @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            pos_r <= 1'b0;
        end else if (ce) begin
            pos_r <= rise_bit ^ neg_r;
        end
    end

    always @(negedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            neg_r <= 1'b0;
        end else if (ce) begin
            neg_r <= fall_bit ^ pos_r;
        end
    end

    assign q = pos_r ^ neg_r;

endmodule // ioerp_ddr_out

// ---- ioerp_pin_cell.v ----
// Purpose: one pin cell with input, output and enable paths
// Assumes: pclk is the core full-rate clock; half rate by phase
// Notes:   settings over APB, zero wait states while ce is high
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "ioerp_consts.vh"
module ioerp_pin_cell #(
    parameter REGS_PRESENT = 1,
    parameter LANE_ID      = 0,
    parameter PIN_ID       = 0
) (
    input  wire        pclk,             // Core full-rate clock
    input  wire        presetn,          // Async reset, low
    input  wire        ce,               // Clock enable
    input  wire        psel,             // APB select
    input  wire        penable,          // APB enable
    input  wire        pwrite,           // APB write
    input  wire [7:0]  paddr,            // APB byte address
    input  wire [31:0] pwdata,           // APB write data
    output reg  [31:0] prdata,           // APB read data
    output wire        pready,           // APB ready
    output wire        pslverr,          // APB error
    input  wire        core_rst,         // Core path reset, high
    input  wire [3:0]  core_dout,        // Core data to pin
    input  wire [1:0]  core_oe,          // Core output enable
    output wire [3:0]  core_din,         // Pin data to core
    output wire        core_half_phase,  // Half-rate word taken
    input  wire        pin_in,           // Pin level in
    output wire        pin_out,          // Pin data out
    output wire        pin_oe,           // Pin driven when high
    output wire        drive_edge_fast,  // Effective edge speed
    output wire        drive_open_drain, // Open drain on
    output wire        level_keeper_on,  // Keeper on
    output wire        drive_pull_up,    // Weak pull-up on
    output wire        edge_boost_on,    // Pre-emphasis on
    output wire [1:0]  swing_level_select, // Output swing code
    output wire        group_dir_out     // Group direction out
);

    // ----------------------------------------
    // Settings registers
    // ----------------------------------------
    reg  [`IOERP_CTRL_W-1:0] ctrl_r;
    reg  [`IOERP_DRV_W-1:0]  drv_r;
    reg  [2:0]               dly_in_r;
    reg  [2:0]               dly_out_r;

    wire       wr_en;
    wire       sel_ctrl;
    wire       sel_drv;
    wire       sel_dly;
    wire       sel_stat;
    wire       mapped;
    wire [31:0] status_w;
    reg  [31:0] rd_mux;

    assign sel_ctrl = (paddr == `IOERP_ADDR_CTRL);
    assign sel_drv  = (paddr == `IOERP_ADDR_DRIVE);
    assign sel_dly  = (paddr == `IOERP_ADDR_DELAY);
    assign sel_stat = (paddr == `IOERP_ADDR_STATUS);
    assign mapped   = sel_ctrl | sel_drv | sel_dly | sel_stat;
    assign pready   = ce;
    assign pslverr  = psel & penable & ~mapped;
    assign wr_en    = psel & penable & pwrite & ce & mapped;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r    <= `IOERP_CTRL_RESET;
            drv_r     <= `IOERP_DRV_RESET;
            dly_in_r  <= 3'h0;
            dly_out_r <= 3'h0;
        end else if (wr_en) begin
            if (sel_ctrl) begin
                ctrl_r <= pwdata[`IOERP_CTRL_W-1:0];
            end
            if (sel_drv) begin
                drv_r <= pwdata[`IOERP_DRV_W-1:0];
                // Keeper wins when both are asked for
                drv_r[`IOERP_DRV_PULL_UP] <= pwdata[`IOERP_DRV_PULL_UP]
                    & ~pwdata[`IOERP_DRV_KEEPER];
            end
            if (sel_dly) begin
                dly_in_r  <= pwdata[`IOERP_DLY_IN_HI:`IOERP_DLY_IN_LO];
                dly_out_r <= pwdata[`IOERP_DLY_OUT_HI:`IOERP_DLY_OUT_LO];
            end
        end
    end

    always @* begin
        rd_mux = 32'h0000_0000;
        if (sel_ctrl) begin
            rd_mux[`IOERP_CTRL_W-1:0] = ctrl_r;
        end
        if (sel_drv) begin
            rd_mux[`IOERP_DRV_W-1:0] = drv_r;
        end
        if (sel_dly) begin
            rd_mux[`IOERP_DLY_IN_HI:`IOERP_DLY_IN_LO]   = dly_in_r;
            rd_mux[`IOERP_DLY_OUT_HI:`IOERP_DLY_OUT_LO] = dly_out_r;
        end
        if (sel_stat) begin
            rd_mux = status_w;
        end
    end

    // Read data loaded in the setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (ce && psel && !penable) begin
            prdata <= rd_mux;
        end
    end

    // ----------------------------------------
    // Driver settings
    // ----------------------------------------
    assign drive_edge_fast = drv_r[`IOERP_DRV_EDGE_FAST]
        | drv_r[`IOERP_DRV_SERIES] | drv_r[`IOERP_DRV_ODT];
    assign drive_open_drain   = drv_r[`IOERP_DRV_OPEN_DRAIN];
    assign level_keeper_on    = drv_r[`IOERP_DRV_KEEPER];
    assign drive_pull_up      = drv_r[`IOERP_DRV_PULL_UP];
    assign edge_boost_on      = drv_r[`IOERP_DRV_BOOST];
    assign swing_level_select = drv_r[`IOERP_DRV_SWING_HI:`IOERP_DRV_SWING_LO];
    assign group_dir_out      = ctrl_r[`IOERP_CTRL_GRP_OUT];

    // ----------------------------------------
    // Mode decode and path reset
    // ----------------------------------------
    localparam [0:0] HAS_REGS = (REGS_PRESENT != 0);

    wire in_ddr   = ctrl_r[`IOERP_CTRL_IN_DDR];
    wire out_ddr  = ctrl_r[`IOERP_CTRL_OUT_DDR];
    wire half     = ctrl_r[`IOERP_CTRL_HALF];
    wire sync_rst = ctrl_r[`IOERP_CTRL_SYNC_RST];
    wire in_byp   = ~HAS_REGS | ctrl_r[`IOERP_CTRL_IN_BYP];
    wire out_byp  = ~HAS_REGS | ctrl_r[`IOERP_CTRL_OUT_BYP];
    wire oe_byp   = ~HAS_REGS | ctrl_r[`IOERP_CTRL_OE_BYP];

    wire path_rst_n = presetn & ~(core_rst & ~sync_rst);
    wire path_clr   = core_rst & sync_rst;

    // ----------------------------------------
    // Half-rate phase
    // ----------------------------------------
    reg phase_r;

    always @(posedge pclk or negedge path_rst_n) begin
        if (!path_rst_n) begin
            phase_r <= 1'b0;
        end else if (ce) begin
            if (path_clr || !half) begin
                phase_r <= 1'b0;
            end else begin
                phase_r <= ~phase_r;
            end
        end
    end

    assign core_half_phase = half & ~phase_r;

    // ----------------------------------------
    // Output and enable gearing
    // ----------------------------------------
    reg  [1:0] ow_r;
    reg  [1:0] ohold_r;
    reg        oe_r;
    reg        oehold_r;
    wire [2:0] o_dly;
    wire       ddr_q;

    always @(posedge pclk or negedge path_rst_n) begin
        if (!path_rst_n) begin
            ow_r     <= 2'h0;
            ohold_r  <= 2'h0;
            oe_r     <= 1'b0;
            oehold_r <= 1'b0;
        end else if (ce) begin
            if (path_clr) begin
                ow_r     <= 2'h0;
                ohold_r  <= 2'h0;
                oe_r     <= 1'b0;
                oehold_r <= 1'b0;
            end else if (half && !phase_r) begin
                ow_r     <= core_dout[1:0];
                ohold_r  <= core_dout[3:2];
                oe_r     <= core_oe[0];
                oehold_r <= core_oe[1];
            end else if (half) begin
                ow_r <= ohold_r;
                oe_r <= oehold_r;
            end else begin
                ow_r <= core_dout[1:0];
                oe_r <= core_oe[0];
            end
        end
    end

    ioerp_delay_chain #(
        .W     (3),
        .DEPTH (`IOERP_DLY_DEPTH),
        .SELW  (3)
    ) u_out_dly (
        .pclk  (pclk),
        .rst_n (path_rst_n),
        .ce    (ce),
        .clr   (path_clr),
        .din   ({oe_r, ow_r}),
        .tap   (dly_out_r),
        .dout  (o_dly)
    );

    ioerp_ddr_out u_ddr_out (
        .pclk   (pclk),
        .rst_n  (path_rst_n),
        .ce     (ce),
        .clr    (path_clr),
        .ddr_en (out_ddr),
        .d_rise (o_dly[0]),
        .d_fall (o_dly[1]),
        .q      (ddr_q)
    );

    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    wire data_eff = out_byp ? core_dout[0] : ddr_q;
    wire oe_eff   = oe_byp ? core_oe[0] : o_dly[2];

    assign pin_out = drive_open_drain ? 1'b0 : data_eff;
    assign pin_oe  = drive_open_drain ? (oe_eff & ~data_eff) : oe_eff;

    // ----------------------------------------
    // Input capture
    // ----------------------------------------
    reg  rs1_r;
    reg  rs2_r;
    reg  rs3_r;
    reg  fs1_r;
    reg  fs2_r;
    reg  fs3_r;
    wire [1:0] i_dly;
    wire [1:0] iw;
    reg  [1:0] ihold_r;
    reg  [3:0] din_r;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rs1_r <= 1'b0;
            rs2_r <= 1'b0;
            rs3_r <= 1'b0;
            fs3_r <= 1'b0;
        end else if (ce) begin
            rs1_r <= pin_in;
            rs2_r <= rs1_r;
            rs3_r <= rs2_r;
            fs3_r <= fs2_r;
        end
    end

    always @(negedge pclk or negedge presetn) begin
        if (!presetn) begin
            fs1_r <= 1'b0;
            fs2_r <= 1'b0;
        end else if (ce) begin
            fs1_r <= pin_in;
            fs2_r <= fs1_r;
        end
    end

    ioerp_delay_chain #(
        .W     (2),
        .DEPTH (`IOERP_DLY_DEPTH),
        .SELW  (3)
    ) u_in_dly (
        .pclk  (pclk),
        .rst_n (path_rst_n),
        .ce    (ce),
        .clr   (path_clr),
        .din   ({fs3_r, rs3_r}),
        .tap   (dly_in_r),
        .dout  (i_dly)
    );

    assign iw = in_ddr ? i_dly : {1'b0, i_dly[0]};

    always @(posedge pclk or negedge path_rst_n) begin
        if (!path_rst_n) begin
            ihold_r <= 2'h0;
            din_r   <= 4'h0;
        end else if (ce) begin
            if (path_clr) begin
                ihold_r <= 2'h0;
                din_r   <= 4'h0;
            end else if (half && !phase_r) begin
                ihold_r <= iw;
            end else if (half) begin
                din_r <= {iw, ihold_r};
            end else begin
                din_r <= {2'h0, iw};
            end
        end
    end

    assign core_din = in_byp ? {3'h0, rs2_r} : din_r;

    // ----------------------------------------
    // Status
    // ----------------------------------------
    localparam [31:0] LANE_I = LANE_ID % `IOERP_LANES;
    localparam [31:0] PIN_I  = PIN_ID % `IOERP_PINS_PER_LANE;

    assign status_w = {20'h0, PIN_I[3:0], 2'h0, LANE_I[1:0],
                       phase_r, HAS_REGS, drive_edge_fast, rs2_r};

endmodule // ioerp_pin_cell

// ---- ioerp_chk_asserts.sv ----
// Purpose: port assertions for the pin cell
// Assumes: one pclk domain, presetn async low
// Notes:   bound to every ioerp_pin_cell
`timescale 1ns/100ps
`include "ioerp_consts.vh"
module ioerp_chk (
    input logic       pclk,              // Clock
    input logic       presetn,           // Reset, low
    input logic       ce,                // Clock enable
    input logic       psel,              // Select
    input logic       penable,           // Enable
    input logic [7:0] paddr,             // Address
    input logic       pready,            // Ready
    input logic       pslverr,           // Error
    input logic       core_rst,          // Path reset
    input logic [3:0] core_din,          // To core
    input logic       core_half_phase,   // Word slot
    input logic       pin_out,           // Pin data
    input logic       drive_edge_fast,   // Edge speed
    input logic       drive_open_drain,  // Open drain
    input logic       level_keeper_on,   // Keeper
    input logic       drive_pull_up,     // Pull-up
    input logic       edge_boost_on,     // Boost
    input logic [1:0] swing_level_select // Swing
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic mapped;
    assign mapped = paddr inside {`IOERP_ADDR_CTRL, `IOERP_ADDR_DRIVE, `IOERP_ADDR_DELAY,
                                  `IOERP_ADDR_STATUS};
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_reset_left;
        $rose(presetn);
    endsequence
    a_ready_ce: assert property (pready == ce)
        else $error("ready differs from clock enable");
    a_err_decode: assert property (s_access |-> pslverr == !mapped)
        else $error("error flag wrong for address");
    a_err_idle: assert property (!(psel && penable) |-> !pslverr)
        else $error("error flag outside access");
    a_drive_dflt: assert property (s_reset_left |->
        drive_edge_fast && edge_boost_on && swing_level_select == 2'h2)
        else $error("driver defaults wrong");
    a_option_dflt: assert property (s_reset_left |->
        !drive_open_drain && !level_keeper_on && !drive_pull_up)
        else $error("option defaults wrong");
    a_keep_pull_excl: assert property (!(level_keeper_on && drive_pull_up))
        else $error("keeper and pull-up both on");
    a_od_pin_low: assert property (drive_open_drain && $past(drive_open_drain) |-> !pin_out)
        else $error("open drain drives high");
    a_hold_no_ce: assert property (!ce && !core_rst ##1 !core_rst |-> $stable(core_din))
        else $error("core data moved without enable");
    a_rst_clears: assert property (core_rst && ce |=> core_din[3:1] == 3'h0)
        else $error("path reset left data");
    a_half_alt: assert property (core_half_phase && ce && !core_rst |=> !core_half_phase)
        else $error("word slot two cycles running");
endmodule // ioerp_chk

bind ioerp_pin_cell ioerp_chk chk_u (.pclk, .presetn, .ce, .psel, .penable, .paddr, .pready,
    .pslverr, .core_rst, .core_din, .core_half_phase, .pin_out, .drive_edge_fast,
    .drive_open_drain, .level_keeper_on, .drive_pull_up, .edge_boost_on, .swing_level_select);

// ---- ioerp_pin_model.sv ----
// Purpose: pin wire and far-side driver for one pin
// Assumes: far side drives only an input group
// Notes:   undriven wire without pull or keeper toggles
`timescale 1ns/100ps
module ioerp_pin_model (
    input  logic pclk,      // Core clock
    input  logic pin_out,   // Cell data
    input  logic pin_oe,    // Cell drives
    input  logic group_out, // Group is output
    input  logic ext_r,     // Level at rising edge
    input  logic ext_f,     // Level at falling edge
    input  logic pull_up,   // Weak pull-up
    input  logic keeper,    // Level keeper
    output logic pin_in     // Wire level
);
    logic far_v = 1'h0;
    logic last_v = 1'h0;
    logic float_v = 1'h0;
    // Level changes at each edge, seen by the opposite one
    always @(pclk) far_v <= pclk ? ext_f : ext_r;
    always @(posedge pclk) begin
        last_v  <= pin_in;
        float_v <= ~float_v;
    end
    always @* begin
        if (pin_oe)
            pin_in = pin_out;
        else if (!group_out)
            pin_in = far_v;
        else if (pull_up)
            pin_in = 1'h1;
        else if (keeper)
            pin_in = last_v;
        else
            pin_in = float_v;
    end
endmodule // ioerp_pin_model

// ---- tb.sv ----
// Purpose: self-checking bench for the pin cell
// Assumes: zero-wait APB, modes set by registers
// Notes:   pin side through ioerp_pin_model
`timescale 1ns/100ps
`include "ioerp_consts.vh"
module tb;
    localparam logic [7:0] ad_ctl = `IOERP_ADDR_CTRL, ad_drv = `IOERP_ADDR_DRIVE;
    localparam logic [7:0] ad_dly = `IOERP_ADDR_DELAY, ad_sts = `IOERP_ADDR_STATUS;
    logic        pclk = 1'h0, presetn = 1'h0, ce = 1'h1, core_rst = 1'h0;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  core_dout = 4'h0, core_din;
    logic [1:0]  core_oe = 2'h0, swing_level_select;
    logic        pready, pslverr, core_half_phase, pin_in, pin_out, pin_oe, group_dir_out;
    logic        drive_edge_fast, drive_open_drain, level_keeper_on, drive_pull_up, edge_boost_on;
    logic        ext_r = 1'h0, ext_f = 1'h0, er;
    int          n_fail = 0, check_count = 0, lat0, lat3;

    always #5 pclk = ~pclk;

    ioerp_pin_cell #(.LANE_ID(2), .PIN_ID(11)) dut_u (.pclk, .presetn, .ce, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .core_rst, .core_dout, .core_oe,
        .core_din, .core_half_phase, .pin_in, .pin_out, .pin_oe, .drive_edge_fast,
        .drive_open_drain, .level_keeper_on, .drive_pull_up, .edge_boost_on,
        .swing_level_select, .group_dir_out);
    ioerp_pin_model pm_u (.pclk, .pin_out, .pin_oe, .group_out(group_dir_out), .ext_r, .ext_f,
        .pull_up(drive_pull_up), .keeper(level_keeper_on), .pin_in);

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'h1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Edges from a data change to the pin, for one tap setting
    task automatic lat(input logic [31:0] taps, output int n);
        wr(ad_dly, taps);
        core_dout <= 4'h0;
        cyc(12);
        core_dout <= 4'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pin_out !== 1'h1 && n < 40);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Whole run is well under 1000 cycles
    initial begin
        #20000;
        n_fail++;
        final_report;
    end

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        chk({drive_edge_fast, edge_boost_on, swing_level_select}, 4'he);
        chk({drive_open_drain, level_keeper_on, drive_pull_up}, 3'h0);
        rdc(ad_drv, 32'h51);
        apb(1'h0, ad_sts, 32'h0);
        chk(rd & 32'hf36, 32'hb26);
        wr(8'h10, 32'hff);
        chk(er, 1'h1);
        rdc(8'h10, 32'h0);
        wr(ad_ctl, 32'h1ff);
        rdc(ad_ctl, 32'hff);
        chk(er, 1'h0);
        chk(group_dir_out, 1'h1);
        for (int k = 0; k < 4; k++) begin
            wr(ad_drv, k << 5);
            chk(swing_level_select, k);
            chk({drive_edge_fast, edge_boost_on}, 2'h0);
        end
        wr(ad_drv, 32'h80);
        chk(drive_edge_fast, 1'h1);
        wr(ad_drv, 32'h100);
        chk(drive_edge_fast, 1'h1);
        wr(ad_drv, 32'h4);
        chk({level_keeper_on, drive_pull_up}, 2'h2);
        wr(ad_drv, 32'h8);
        chk({level_keeper_on, drive_pull_up}, 2'h1);
        wr(ad_drv, 32'hc);
        chk({level_keeper_on, drive_pull_up}, 2'h2);
        wr(ad_ctl, 32'h0);
        core_oe <= 2'h1;
        wr(ad_drv, 32'h2);
        cyc(3);
        chk({pin_oe, pin_out}, 2'h2);
        core_dout <= 4'h1;
        cyc(3);
        chk(pin_oe, 1'h0);
        wr(ad_drv, 32'h51);
        wr(ad_ctl, 32'h2);
        core_dout <= 4'h2;
        cyc(3);
        #2 chk({pin_oe, pin_out}, 2'h2);
        #5 chk({pin_oe, pin_out}, 2'h3);
        cyc(1);
        wr(ad_ctl, 32'h0);
        cyc(2);
        #7 chk(pin_out, 1'h0);
        cyc(1);
        wr(ad_ctl, 32'h4);
        core_dout <= 4'h4;
        cyc(4);
        #2;
        // Slot seen mid-cycle: words load at the next edge, show one later
        while (core_half_phase !== 1'h1) #10;
        cyc(2);
        #2 chk(pin_out, 1'h0);
        @(posedge pclk);
        #2 chk(pin_out, 1'h1);
        chk(core_half_phase, 1'h0);
        cyc(1);
        wr(ad_ctl, 32'h0);
        lat(32'h0, lat0);
        lat(32'h300, lat3);
        chk(lat3 - lat0, 32'h3);
        wr(ad_dly, 32'h0);
        core_oe <= 2'h0;
        wr(ad_ctl, 32'h1);
        ext_r <= 1'h1;
        cyc(12);
        chk(core_din[1:0], 2'h1);
        ext_r <= 1'h0;
        ext_f <= 1'h1;
        cyc(12);
        chk(core_din[1:0], 2'h2);
        wr(ad_ctl, 32'h8);
        cyc(4);
        chk(core_din, 4'h0);
        ext_r <= 1'h1;
        cyc(4);
        chk(core_din, 4'h1);
        core_dout <= 4'h0;
        wr(ad_ctl, 32'h30);
        core_dout <= 4'h1;
        core_oe <= 2'h1;
        #2 chk({pin_oe, pin_out}, 2'h3);
        cyc(1);
        wr(ad_ctl, 32'h0);
        cyc(3);
        ce <= 1'h0;
        core_rst <= 1'h1;
        cyc(2);
        chk(pin_out, 1'h0);
        chk(pready, 1'h0);
        core_rst <= 1'h0;
        ce <= 1'h1;
        wr(ad_ctl, 32'h40);
        cyc(3);
        ce <= 1'h0;
        core_rst <= 1'h1;
        cyc(2);
        chk(pin_out, 1'h1);
        ce <= 1'h1;
        cyc(2);
        chk(pin_out, 1'h0);
        core_rst <= 1'h0;
        cyc(2);
        final_report;
    end
endmodule // tb
